// File: core/rcm_mailbox.v
// remote open command mailbox: buffer capture, command check, status registers
`timescale 1ns/1ns
`include "rcm_regs.vh"
module rcm_mailbox #(
  parameter EXEC_CYCLES = `RCM_EXEC_CYCLES
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_frame_end,
  input wire [31:0] i_admin_pw,
  input wire [31:0] i_oper_pw,
  input wire i_breaker_open,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rvalid,
  output reg o_open_cmd,
  output wire o_busy
);
  localparam S_IDLE = 3'h0;
  localparam S_READ = 3'h1;
  localparam S_CAPT = 3'h2;
  localparam S_CHECK = 3'h3;
  localparam S_WAIT = 3'h4;
  localparam S_DONE = 3'h5;

  // =====================================================
  // pin synchroniser
  reg brk_meta_q;
  reg brk_sync_q;
  always @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      brk_meta_q <= 1'b0;
      brk_sync_q <= 1'b0;
    end
    else
    begin
      brk_meta_q <= i_breaker_open;
      brk_sync_q <= brk_meta_q;
    end
  end

  // =====================================================
  // frame tracking
  reg [2:0] state_q;
  reg [4:0] wr_cnt_q;
  reg [4:0] wr_cnt_d;
  reg rej_pend_q;
  reg [15:0] rej_code_q;
  wire [15:0] buf_off = i_reg_addr - `RCM_REG_CMD_BUF;
  wire in_buf = (i_reg_addr >= `RCM_REG_CMD_BUF) && (buf_off < 16'h0014);
  wire busy = (state_q != S_IDLE);
  // buffer frozen while executing so the running command keeps its words
  wire mem_we = i_reg_wr && in_buf && !busy;
  wire frame_ok = i_frame_end && (wr_cnt_d == `RCM_BUF_WORDS);
  assign o_busy = busy;

  always @*
  begin
    wr_cnt_d = wr_cnt_q;
    if (i_reg_wr)
    begin
      if (i_reg_addr == `RCM_REG_CMD_BUF)
        wr_cnt_d = 5'h01;
      else if (in_buf && (buf_off[4:0] == wr_cnt_q))
        wr_cnt_d = wr_cnt_q + 5'h01;
      else
        wr_cnt_d = 5'h1F;
    end
  end

  always @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      wr_cnt_q <= 5'h00;
    else if (i_frame_end)
      wr_cnt_q <= 5'h00;
    else
      wr_cnt_q <= wr_cnt_d;
  end

  // =====================================================
  // buffer and executor
  reg [4:0] rd_idx_q;
  wire [15:0] rd_word;
  reg [15:0] code_q;
  reg [15:0] dest_q;
  reg [31:0] pw_q;
  reg [15:0] echo_q;
  reg [15:0] result_q;
  reg [7:0] err_q;
  reg [15:0] cnt_q;
  reg [7:0] err_d;

  rcm_buf_mem #(
    .DEPTH(20),
    .AW(5),
    .DW(16)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_wr_en(mem_we),
    .i_wr_idx(buf_off[4:0]),
    .i_wr_data(i_reg_wdata),
    .i_rd_idx(rd_idx_q),
    .o_rd_data(rd_word)
  );

  always @*
  begin
    err_d = `RCM_ERR_OK;
    if (code_q != `RCM_CODE_OPEN)
      err_d = `RCM_ERR_NOT_SUPP;
    else if (dest_q != `RCM_DEST_OPEN)
      err_d = `RCM_ERR_BAD_DEST;
    else if ((pw_q != i_admin_pw) && (pw_q != i_oper_pw))
      err_d = `RCM_ERR_PASSWORD;
    else if (brk_sync_q)
      err_d = `RCM_ERR_ALR_OPEN;
  end

  always @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= S_IDLE;
      rd_idx_q <= 5'h00;
      code_q <= 16'h0000;
      dest_q <= 16'h0000;
      pw_q <= 32'h00000000;
      echo_q <= `RCM_ECHO_RESET;
      result_q <= `RCM_RESULT_RESET;
      err_q <= 8'h00;
      cnt_q <= 16'h0000;
      o_open_cmd <= 1'b0;
      rej_pend_q <= 1'b0;
      rej_code_q <= 16'h0000;
    end
    else
    begin
      o_open_cmd <= 1'b0;
      // second command during execution is remembered, answered at the end
      if (busy && i_reg_wr && (i_reg_addr == `RCM_REG_CMD_BUF))
        rej_code_q <= i_reg_wdata;
      if (busy && frame_ok)
        rej_pend_q <= 1'b1;
      case (state_q)
        S_IDLE:
        begin
          rd_idx_q <= 5'h00;
          if (frame_ok)
            state_q <= S_READ;
        end
        S_READ:
          state_q <= S_CAPT;
        S_CAPT:
        begin
          state_q <= S_READ;
          if (rd_idx_q == 5'h00)
          begin
            code_q <= rd_word;
            rd_idx_q <= 5'h02;
          end
          else if (rd_idx_q == 5'h02)
          begin
            dest_q <= rd_word;
            rd_idx_q <= 5'h04;
          end
          else if (rd_idx_q == 5'h04)
          begin
            pw_q[31:16] <= rd_word;
            rd_idx_q <= 5'h05;
          end
          else
          begin
            pw_q[15:0] <= rd_word;
            state_q <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          err_q <= err_d;
          if (err_d == `RCM_ERR_OK)
            o_open_cmd <= 1'b1;
          cnt_q <= 16'h0000;
          state_q <= S_WAIT;
        end
        S_WAIT:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= EXEC_CYCLES - 1)
            state_q <= S_DONE;
        end
        default:
        begin
          if (rej_pend_q || (busy && frame_ok))
          begin
            echo_q <= rej_code_q;
            result_q <= {8'h00, `RCM_ERR_PREV_BUSY};
            rej_pend_q <= 1'b0;
          end
          else
          begin
            echo_q <= code_q;
            result_q <= {dest_q[15:8], err_q};
          end
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // register read port; buffer is write only and reads zero
  always @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd)
        o_reg_rdata <= o_reg_rdata;
      else if (i_reg_addr == `RCM_REG_RESULT)
        o_reg_rdata <= busy ? `RCM_STAT_BUSY : result_q;
      else if (i_reg_addr == `RCM_REG_ECHO)
        o_reg_rdata <= echo_q;
      else
        o_reg_rdata <= 16'h0000;
    end
  end
endmodule // rcm_mailbox

// File: core/rcm_regs.vh
// register numbers, field values and timing for the remote open command mailbox
// Operation
// - word zero holds 904, the open breaker request
// - words four and five carry the ASCII password, checked against credentials
// - status register 8021 reads 0x0003 while a command executes
// - register 8020 shows the code of the last processed command
// - low byte of 8021 holds result code, zero means success
// - wrong or insufficient password gives result code 1
// - unsupported command gives result code 0x13
// - open request while breaker already open gives 0x99
// - new command while one executes is rejected with 0x9E
`ifndef RCM_REGS_VH
`define RCM_REGS_VH
`define RCM_REG_CMD_BUF 16'h1F40
`define RCM_REG_ECHO 16'h1F54
`define RCM_REG_RESULT 16'h1F55
`define RCM_BUF_WORDS 5'h14
`define RCM_CODE_OPEN 16'h0388
`define RCM_DEST_OPEN 16'h1201
`define RCM_STAT_BUSY 16'h0003
`define RCM_ERR_OK 8'h00
`define RCM_ERR_PASSWORD 8'h01
`define RCM_ERR_NOT_SUPP 8'h13
`define RCM_ERR_BAD_DEST 8'h18
`define RCM_ERR_ALR_OPEN 8'h99
`define RCM_ERR_PREV_BUSY 8'h9E
`define RCM_ECHO_RESET 16'h0000
`define RCM_RESULT_RESET 16'h0000
`define RCM_CLK_MHZ 20
`define RCM_EXEC_TIME_US 10
`define RCM_EXEC_CYCLES (`RCM_EXEC_TIME_US * `RCM_CLK_MHZ)
`endif

// File: core/rcm_buf_mem.v
// twenty-word command buffer with registered read port
`timescale 1ns/1ns
module rcm_buf_mem #(
  parameter DEPTH = 20,
  parameter AW = 5,
  parameter DW = 16
) (
  input wire i_sys_clk,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_idx,
  input wire [DW-1:0] i_wr_data,
  input wire [AW-1:0] i_rd_idx,
  output reg [DW-1:0] o_rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];
  always @(posedge i_sys_clk)
  begin
    if (i_wr_en)
      mem[i_wr_idx] <= i_wr_data;
    o_rd_data <= mem[i_rd_idx];
  end
endmodule // rcm_buf_mem

// File: bench/rcm_mailbox_monitor.sv
// port assertions for the command mailbox
`timescale 1ns/1ns
module rcm_mailbox_monitor (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_reg_rd,
  input wire [15:0] i_reg_addr,
  input wire i_breaker_open,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_rvalid,
  input wire o_open_cmd,
  input wire o_busy
);
  // ==========
  // properties
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  a_read_answered: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_read_caused: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("answer without read");
  a_busy_status: assert property ((i_reg_rd && i_reg_addr == 16'h1F55 && o_busy)
    |=> o_reg_rdata == 16'h0003) else $error("busy status wrong");
  a_buf_unread: assert property ((i_reg_rd && i_reg_addr == 16'h1F40)
    |=> o_reg_rdata == 16'h0000) else $error("buffer readable");
  a_open_single: assert property (o_open_cmd |=> !o_open_cmd)
    else $error("open pulse too long");
  a_open_busy: assert property (o_open_cmd |-> o_busy)
    else $error("open outside command");
  // breaker held steady by the bench around each frame, so 3 cycles back is safe
  a_open_closed: assert property (o_open_cmd |-> !$past(i_breaker_open, 3))
    else $error("open while open");
  a_busy_holds: assert property ($rose(o_busy) |-> o_busy[*8])
    else $error("busy too short");
endmodule // rcm_mailbox_monitor
bind rcm_mailbox rcm_mailbox_monitor u_mon (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_breaker_open(i_breaker_open),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_open_cmd(o_open_cmd),
  .o_busy(o_busy));

// File: bench/rcm_master_model.sv
// remote master model: buffer frames and register reads
`timescale 1ns/1ns
module rcm_master_model (
  input wire i_sys_clk,
  output reg o_reg_wr,
  output reg o_reg_rd,
  output reg [15:0] o_reg_addr,
  output reg [15:0] o_reg_wdata,
  output reg o_frame_end
);
  // ==========
  // frame build
  initial
  begin
    {o_reg_wr, o_reg_rd, o_frame_end, o_reg_addr, o_reg_wdata} = 35'h0;
  end
  function [15:0] word(input [4:0] i, input [15:0] code, input [15:0] dest, input [31:0] pw);
    case (i)
      5'h00: word = code;
      5'h01: word = 16'h000A;
      5'h02: word = dest;
      5'h03: word = 16'h0001;
      5'h04: word = pw[31:16];
      5'h05: word = pw[15:0];
      5'h11: word = 16'h1F53;
      5'h12: word = 16'h1F54;
      5'h13: word = 16'h1F55;
      default: word = 16'h0000;
    endcase
  endfunction
  task frame(input [15:0] code, input [15:0] dest, input [31:0] pw);
    integer i;
    begin
      for (i = 0; i < 20; i = i + 1)
      begin
        @(negedge i_sys_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = 16'h1F40 + i[15:0];
        o_reg_wdata = word(i[4:0], code, dest, pw);
        o_frame_end = (i == 19);
      end
      @(negedge i_sys_clk);
      o_reg_wr = 1'b0;
      o_frame_end = 1'b0;
      // released data must not look like a held word
      o_reg_wdata = ~o_reg_wdata;
    end
  endtask
  task rd(input [15:0] a);
    begin
      @(negedge i_sys_clk);
      o_reg_rd = 1'b1;
      o_reg_addr = a;
      @(negedge i_sys_clk);
      o_reg_rd = 1'b0;
    end
  endtask
endmodule // rcm_master_model

// File: bench/rcm_mailbox_bench.sv
// self-checking bench for the command mailbox
`timescale 1ns/1ns
module rcm_mailbox_bench;
  reg sys_clk, reset, brk;
  reg [31:0] adm, opr;
  wire wr, rd, fe, rvalid, open_cmd, busy;
  wire [15:0] addr, wdata, rdata;
  integer err_count = 0;
  integer n_checks = 0;
  integer n_open = 0;
  integer exp_open = 0;
  integer k;
  reg [15:0] exp_q[$];
  // ==========
  // harness
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  rcm_master_model m (.i_sys_clk(sys_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_frame_end(fe));
  // long enough that a second frame lands wholly inside the first command
  rcm_mailbox #(.EXEC_CYCLES(40)) dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_frame_end(fe),
    .i_admin_pw(adm), .i_oper_pw(opr), .i_breaker_open(brk), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_open_cmd(open_cmd), .o_busy(busy));
  // counted mid-cycle, where the registered pulse has settled
  always @(negedge sys_clk)
    if (open_cmd === 1'b1) n_open = n_open + 1;
  always @(negedge sys_clk)
    if (rvalid === 1'b1)
    begin
      n_checks = n_checks + 1;
      if (exp_q.size() == 0 || rdata !== exp_q[0])
      begin
        err_count = err_count + 1;
        $display("Error %0t: read data %h", $time, rdata);
      end
      if (exp_q.size() != 0) exp_q.delete(0);
    end
  task test_done;
    begin
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task rd_chk(input [15:0] a, input [15:0] e);
    begin
      exp_q.push_back(e);
      m.rd(a);
    end
  endtask
  task run(input [15:0] code, input [15:0] dest, input [31:0] pw, input b, input [7:0] err,
    input integer opens, input [15:0] code2);
    begin
      @(negedge sys_clk);
      brk = b;
      repeat (4) @(negedge sys_clk);
      m.frame(code, dest, pw);
      if (code2 != 16'h0000) m.frame(code2, dest, pw);
      rd_chk(16'h1F55, 16'h0003);
      for (k = 0; k < 200 && busy !== 1'b0; k = k + 1) @(negedge sys_clk);
      if (busy !== 1'b0)
      begin
        err_count = err_count + 1;
        $display("Error %0t: command never finished", $time);
      end
      rd_chk(16'h1F54, (code2 != 16'h0000) ? code2 : code);
      rd_chk(16'h1F55, (code2 != 16'h0000) ? 16'h009E : {dest[15:8], err});
      exp_open = exp_open + opens;
      n_checks = n_checks + 1;
      if (n_open != exp_open)
      begin
        err_count = err_count + 1;
        $display("Error %0t: open pulses %0d", $time, n_open);
      end
    end
  endtask
  // ==========
  // tests
  initial
  begin
    reset = 1'b1;
    brk = 1'b0;
    adm = $urandom(71930);
    opr = $urandom;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    rd_chk(16'h1F54, 16'h0000);
    rd_chk(16'h1F55, 16'h0000);
    rd_chk(16'h1F40, 16'h0000);
    rd_chk(16'h0000, 16'h0000);
    run(16'h0388, 16'h1201, adm, 1'b0, 8'h00, 1, 16'h0000);
    run(16'h0388, 16'h1201, opr, 1'b0, 8'h00, 1, 16'h0000);
    run(16'h0388, 16'h1201, adm ^ 32'h1, 1'b0, 8'h01, 0, 16'h0000);
    run(16'h0300, 16'h1201, adm, 1'b0, 8'h13, 0, 16'h0000);
    run(16'h0388, 16'h0300, adm, 1'b0, 8'h18, 0, 16'h0000);
    run(16'h0388, 16'h1201, adm, 1'b1, 8'h99, 0, 16'h0000);
    run(16'h0388, 16'h1201, adm, 1'b0, 8'h00, 1, 16'h0300);
    test_done;
  end
  initial
  begin
    #250000;
    err_count = err_count + 1;
    test_done;
  end
endmodule // rcm_mailbox_bench
